//--- core/ais_pkg.sv
/*
 * Constants for the converter input and reference select block.
 * Assumes an 8-bit special-function bus with a page register outside.
 */
`default_nettype none
package ais_pkg;
    localparam logic [7:0] AIS_MUX_SEL_ADDR = 8'hbb;
    localparam logic [7:0] AIS_MUX_SEL_PAGE = 8'h00;
    localparam logic [7:0] AIS_REF_CTRL_ADDR = 8'hd2;
    localparam logic [7:0] AIS_REF_CTRL_PAGE = 8'h0f;
    localparam logic [4:0] AIS_POS_RESET = 5'h1f;
    localparam logic [4:0] AIS_POS_TEMP = 5'h10;
    localparam logic [4:0] AIS_POS_REGOUT = 5'h11;
    localparam logic [4:0] AIS_POS_SUPPLY = 5'h12;
    localparam logic [4:0] AIS_POS_GROUND = 5'h13;
    localparam int AIS_POS_LSB = 0;
    localparam int AIS_TEMP_EN_BIT = 2;
    localparam int AIS_REF_SEL_LSB = 3;
    localparam int AIS_GND_SEL_BIT = 5;
    localparam logic [7:0] AIS_REF_CTRL_RESET = 8'h00;
    localparam logic [7:0] AIS_REF_CTRL_MASK = 8'h3c;
    typedef enum logic [1:0] {
        AIS_REF_EXTERNAL = 2'b00,
        AIS_REF_SUPPLY = 2'b01,
        AIS_REF_DIGITAL = 2'b10,
        AIS_REF_INTERNAL = 2'b11
    } ais_ref_t;
    typedef struct packed {
        logic [4:0] pos_code;
        ais_ref_t ref_sel;
        logic gnd_sel;
        logic temp_en;
        logic [7:0] rdata;
    } ais_state_t;
endpackage
`default_nettype wire

//--- core/ais_select.sv
/*
 * Converter input multiplexer and reference select registers.
 * Assumes SFR bus inputs synchronous to clk_sys; page value from outside, decoded here.
 */
`default_nettype none
// How it works
// - Five-bit input code picks pin, sensor, supplies
// - Mux register at 0xbb, page 0 only
// - Reference code 00 selects external pin
// - Reference code 11 selects internal 1.6 V
// - Internal reference powered only when converter needs
// - Code 01 supply, 10 regulated 1.8 V
// - Ground select bit uses analog ground pin
// - Sensor enable bit powers temperature sensor
module ais_select import ais_pkg::*; (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic conv_ref_request,
    output logic [4:0] positive_input_code,
    output logic [15:0] port_pin_select,
    output logic temp_select,
    output logic regout_select,
    output logic supply_select,
    output logic ground_select,
    output logic [1:0] reference_source_select,
    output logic ref_external_en,
    output logic ref_supply_en,
    output logic ref_digital_en,
    output logic ref_internal_en,
    output logic analog_ground_select,
    output logic temp_sensor_enable
);
    logic [1:0] rst_sync_q;
    logic [1:0] rst_sync_d;
    logic rst_n;
    ais_state_t s_q;
    ais_state_t s_d;
    logic hit_mux;
    logic hit_ref;
    logic wr_mux;
    logic wr_ref;
    logic rd_mux;
    logic rd_ref;
    logic [7:0] mux_view;
    logic [7:0] ref_view;
    logic [15:0] pin_dec;
    logic temp_dec;
    logic regout_dec;
    logic supply_dec;
    logic ground_dec;
    logic ext_dec;
    logic sup_dec;
    logic dig_dec;
    logic int_dec;

    // Address and page must both match
    function automatic logic sel_hit(
        input logic [7:0] a,
        input logic [7:0] p,
        input logic [7:0] ra,
        input logic [7:0] rp
    );
        sel_hit = (a == ra) && (p == rp);
    endfunction

    // Read image of the mux register, upper bits zero
    function automatic logic [7:0] mux_image(
        input logic [4:0] code
    );
        mux_image = 8'h00;
        mux_image[AIS_POS_LSB +: 5] = code;
    endfunction

    // Read image of the reference control register
    function automatic logic [7:0] ref_image(
        input ais_ref_t rs,
        input logic gs,
        input logic te
    );
        ref_image = 8'h00;
        ref_image[AIS_REF_SEL_LSB +: 2] = rs;
        ref_image[AIS_GND_SEL_BIT] = gs;
        ref_image[AIS_TEMP_EN_BIT] = te;
        ref_image = ref_image & AIS_REF_CTRL_MASK;
    endfunction

    // Reset release through two flops
    always_comb begin
        rst_sync_d = {rst_sync_q[0], 1'b1};
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= rst_sync_d;
        end
    end

    assign rst_n = rst_sync_q[1];

    // Register decode
    assign hit_mux = sel_hit(sfr_addr, sfr_page, AIS_MUX_SEL_ADDR,
                             AIS_MUX_SEL_PAGE);
    assign hit_ref = sel_hit(sfr_addr, sfr_page, AIS_REF_CTRL_ADDR,
                             AIS_REF_CTRL_PAGE);
    assign sfr_hit = hit_mux | hit_ref;
    assign wr_mux = sfr_wr & hit_mux;
    assign wr_ref = sfr_wr & hit_ref;
    assign rd_mux = sfr_rd & hit_mux;
    assign rd_ref = sfr_rd & hit_ref;

    assign mux_view = mux_image(s_q.pos_code);
    assign ref_view = ref_image(s_q.ref_sel, s_q.gnd_sel, s_q.temp_en);

    // Next state
    always_comb begin
        s_d = s_q;
        if (wr_mux) begin
            s_d.pos_code = sfr_wdata[AIS_POS_LSB +: 5];
        end
        if (wr_ref) begin
            s_d.ref_sel = ais_ref_t'(sfr_wdata[AIS_REF_SEL_LSB +: 2]);
            s_d.gnd_sel = sfr_wdata[AIS_GND_SEL_BIT];
            s_d.temp_en = sfr_wdata[AIS_TEMP_EN_BIT];
        end
        s_d.rdata = 8'h00;
        if (rd_mux) begin
            s_d.rdata = mux_view;
        end else if (rd_ref) begin
            s_d.rdata = ref_view;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q.pos_code <= AIS_POS_RESET;
            s_q.ref_sel <= AIS_REF_EXTERNAL;
            s_q.gnd_sel <= AIS_REF_CTRL_RESET[AIS_GND_SEL_BIT];
            s_q.temp_en <= AIS_REF_CTRL_RESET[AIS_TEMP_EN_BIT];
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    // Positive input decode
    always_comb begin
        pin_dec = 16'h0000;
        temp_dec = 1'b0;
        regout_dec = 1'b0;
        supply_dec = 1'b0;
        ground_dec = 1'b0;
        case (s_q.pos_code)
            AIS_POS_TEMP: begin
                temp_dec = 1'b1;
            end
            AIS_POS_REGOUT: begin
                regout_dec = 1'b1;
            end
            AIS_POS_SUPPLY: begin
                supply_dec = 1'b1;
            end
            AIS_POS_GROUND: begin
                ground_dec = 1'b1;
            end
            default: begin
                if (s_q.pos_code[4] == 1'b0) begin
                    pin_dec[s_q.pos_code[3:0]] = 1'b1;
                end
            end
        endcase
    end

    // Reference source decode
    always_comb begin
        ext_dec = 1'b0;
        sup_dec = 1'b0;
        dig_dec = 1'b0;
        int_dec = 1'b0;
        case (s_q.ref_sel)
            AIS_REF_EXTERNAL: begin
                ext_dec = 1'b1;
            end
            AIS_REF_SUPPLY: begin
                sup_dec = 1'b1;
            end
            AIS_REF_DIGITAL: begin
                dig_dec = 1'b1;
            end
            AIS_REF_INTERNAL: begin
                // Powered only while the converter asks for it
                int_dec = conv_ref_request;
            end
            default: begin
                ext_dec = 1'b0;
            end
        endcase
    end

    // Outputs follow the registers, except ref_internal_en, which is also gated by conv_ref_request
    assign sfr_rdata = s_q.rdata;
    assign positive_input_code = s_q.pos_code;

    assign port_pin_select = pin_dec;
    assign temp_select = temp_dec;
    assign regout_select = regout_dec;
    assign supply_select = supply_dec;
    assign ground_select = ground_dec;

    assign reference_source_select = s_q.ref_sel;
    assign ref_external_en = ext_dec;
    assign ref_supply_en = sup_dec;
    assign ref_digital_en = dig_dec;
    assign ref_internal_en = int_dec;

    assign analog_ground_select = s_q.gnd_sel;
    assign temp_sensor_enable = s_q.temp_en;

endmodule
`default_nettype wire

//--- sim/ais_partner.sv
/* Converter model: asks for the reference while it converts.
   Assumes go comes from the bench. */
`default_nettype none
module ais_partner (
    input wire logic clk_sys,
    input wire logic go,
    output logic conv_ref_request
);
    timeunit 1ns; timeprecision 1ps;
    always_ff @(posedge clk_sys) conv_ref_request <= go;
endmodule
`default_nettype wire

//--- sim/ais_select_asserts.sv
/* Port checker for ais_select. Assumes ports named as in the design. */
`default_nettype none
module ais_select_asserts import ais_pkg::*; (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic conv_ref_request,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [4:0] positive_input_code,
    input wire logic [15:0] port_pin_select,
    input wire logic temp_select,
    input wire logic ground_select,
    input wire logic ref_external_en,
    input wire logic ref_internal_en,
    input wire logic analog_ground_select,
    input wire logic temp_sensor_enable,
    input wire logic [1:0] reference_source_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic [4:0] pc = positive_input_code;
    wire logic mux = sfr_addr == AIS_MUX_SEL_ADDR;
    sequence s_wr; sfr_wr && mux && sfr_page == AIS_MUX_SEL_PAGE; endsequence
    sequence s_rd; sfr_rd && mux && sfr_page == AIS_MUX_SEL_PAGE; endsequence
    sequence s_rwr;
        sfr_wr && sfr_addr == AIS_REF_CTRL_ADDR
        && sfr_page == AIS_REF_CTRL_PAGE;
    endsequence
    property p_refwr; s_rwr |=>
        reference_source_select == $past(sfr_wdata[4:3])
        && analog_ground_select == $past(sfr_wdata[5])
        && temp_sensor_enable == $past(sfr_wdata[2]); endproperty
    property p_pin; pc < 5'h10 |-> port_pin_select == 16'h1 << pc; endproperty
    property p_none; pc > 5'h13 |-> !port_pin_select && !ground_select;
    endproperty
    property p_temp; temp_select == (pc == AIS_POS_TEMP); endproperty
    property p_ext; ref_external_en == !reference_source_select; endproperty
    property p_int; ref_internal_en ==
        (&reference_source_select && conv_ref_request); endproperty
    property p_wr; s_wr |=> pc == $past(sfr_wdata[4:0]); endproperty
    property p_rd; s_rd |=> sfr_rdata == {3'h0, $past(pc)}; endproperty
    property p_page; sfr_wr && sfr_page != 8'h00 |=> $stable(pc); endproperty
    a_pin: assert property (p_pin) else $error("pin decode wrong");
    a_none: assert property (p_none) else $error("stray select");
    a_temp: assert property (p_temp) else $error("sensor select");
    a_ext: assert property (p_ext) else $error("external ref");
    a_int: assert property (p_int) else $error("internal ref");
    a_wr: assert property (p_wr) else $error("write lost");
    a_rd: assert property (p_rd) else $error("read value");
    a_page: assert property (p_page) else $error("page ignored");
    a_refwr: assert property (p_refwr) else $error("ref write");
endmodule
bind ais_select ais_select_asserts chk_u (.*);
`default_nettype wire

//--- sim/tb_ais_select.sv
/* Bench for ais_select with the converter model. Assumes nothing else. */
`default_nettype none
module tb_ais_select import ais_pkg::*;;
    timeunit 1ns; timeprecision 1ps;
    logic clk_sys = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, go = 0;
    logic [7:0] sfr_addr = 0, sfr_page = 0, sfr_wdata = 0, sfr_rdata;
    logic [4:0] positive_input_code;
    logic [15:0] port_pin_select;
    logic [1:0] reference_source_select;
    logic temp_select, regout_select, supply_select, ground_select, sfr_hit;
    logic ref_external_en, ref_supply_en, ref_digital_en, ref_internal_en;
    logic analog_ground_select, temp_sensor_enable, conv_ref_request;
    int err_count = 0, n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    ais_select dut_u (.*);
    ais_partner prt_u (.clk_sys, .go, .conv_ref_request);
    task chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [7:0] ad, p, d);
        @(posedge clk_sys) #1 {sfr_wr, sfr_rd} = {w, !w};
        {sfr_addr, sfr_page, sfr_wdata} = {ad, p, d};
        @(posedge clk_sys) #1 {sfr_wr, sfr_rd} = 2'b00;
    endtask
    task t_codes;
        for (int i = 0; i < 32; i++) begin
            acc(1, 8'hbb, 8'h00, 8'he0 | 8'(i));
            chk(port_pin_select, i < 16 ? 32'h1 << i : 0);
            chk({temp_select, regout_select, supply_select, ground_select},
                {i == 16, i == 17, i == 18, i == 19});
            acc(0, 8'hbb, 8'h00, 0);
            chk(sfr_rdata, i);
            chk(sfr_hit, 1);
        end
        $display("input codes done");
    endtask
    task t_page;
        acc(1, 8'hbb, 8'h0f, 8'h02);
        chk(positive_input_code, 5'h1f);
        acc(0, 8'hbb, 8'h0f, 0);
        chk(sfr_rdata, 0);
        chk(sfr_hit, 0);
        $display("page done");
    endtask
    task t_ref;
        for (int k = 0; k < 16; k++) begin
            go = !k[0];
            acc(1, 8'hd2, 8'h0f, 8'(k << 2));
            chk({ref_external_en, ref_supply_en, ref_digital_en},
                {k[2:1] == 0, k[2:1] == 1, k[2:1] == 2});
            chk(ref_internal_en, k[2:1] == 3 && !k[0]);
            chk(reference_source_select, k[2:1]);
            chk(analog_ground_select, k[3]);
            chk(temp_sensor_enable, k[0]);
            acc(0, 8'hd2, 8'h0f, 0);
            chk(sfr_rdata, k << 2);
        end
        $display("reference done");
    endtask
    task t_reset;
        acc(1, 8'hbb, 8'h00, 8'h03);
        @(posedge clk_sys) #1 resetn = 0;
        @(posedge clk_sys) #1 resetn = 1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({positive_input_code, ref_external_en}, {5'h1f, 1'b1});
        chk({analog_ground_select, temp_sensor_enable}, 0);
        $display("reset done");
    endtask
    task wrap_up;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #26 resetn = 1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({positive_input_code, ref_external_en}, {5'h1f, 1'b1});
        t_codes;
        acc(1, 8'hbb, 8'h00, 8'h1f);
        t_page;
        t_ref;
        t_reset;
        wrap_up;
    end
endmodule
`default_nettype wire
